// *** design/spm_ctrl.sv ***
`timescale 1ns/1ns
module spm_ctrl #(
  parameter int unsigned CNT_W       = spm_pkg::WAKE_CNT_W,
  parameter int unsigned WAKE_CYCLES = 32'(spm_pkg::OSC_RESTART_CYC)
) (
  input  wire logic core_clk,
  input  wire logic nrst,
  input  wire logic stop_cmd,
  input  wire logic halt_cmd,
  input  wire logic flag_rd,
  input  wire logic nmi_req,
  input  wire logic int_req,
  input  wire logic ext_rst_n,
  input  wire logic supply_rise,
  output logic      osc_en,
  output logic      cpu_run,
  output logic      periph_run,
  output logic      stop_active,
  output logic      halt_active,
  output logic      wake_pulse,
  output logic      flag_rvalid,
  output logic      flag_rdata,
  output logic      standby_flag
);
  import spm_pkg::*;

  // ---------------------------------------------------------------
  // pin synchronisers
  // ---------------------------------------------------------------
  logic [3:0] pins_s;

  spm_sync #(
    .W (4)
  ) u_sync (
    .core_clk (core_clk),
    .nrst     (nrst),
    .d        ({supply_rise, ext_rst_n, int_req, nmi_req}),
    .q        (pins_s)
  );

  logic nmi_s;
  logic int_s;
  logic xrst_n_s;
  logic rise_s;
  assign nmi_s    = pins_s[0];
  assign int_s    = pins_s[1];
  assign xrst_n_s = pins_s[2];
  assign rise_s   = pins_s[3];

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  typedef struct packed {
    spm_state_t       st;
    logic [CNT_W-1:0] cnt;
    logic             nmi_prev;
    logic             rise_prev;
    logic             flag;
    logic             osc_en;
    logic             cpu_run;
    logic             periph_run;
    logic             wake;
    logic             rvalid;
    logic             rdata;
  } spm_ctrl_t;

  localparam spm_ctrl_t RST_VAL = '{
    st:         SPM_RUN,
    cnt:        '0,
    nmi_prev:   1'b0,
    rise_prev:  1'b0,
    flag:       FLAG_COLD,
    osc_en:     1'b1,
    cpu_run:    1'b1,
    periph_run: 1'b1,
    wake:       1'b0,
    rvalid:     1'b0,
    rdata:      FLAG_COLD
  };

  localparam logic [CNT_W-1:0] WAKE_LOAD = CNT_W'(WAKE_CYCLES - 32'd1);

  spm_ctrl_t r;
  spm_ctrl_t next_r;

  logic nmi_edge;
  logic rise_edge;
  assign nmi_edge  = nmi_s & ~r.nmi_prev;
  assign rise_edge = rise_s & ~r.rise_prev;

  always_comb begin
    next_r           = r;
    next_r.wake      = 1'b0;
    next_r.rvalid    = 1'b0;
    next_r.nmi_prev  = nmi_s;
    next_r.rise_prev = rise_s;
    case (r.st)
      SPM_RUN: begin
        // [RQ1] stop command enters STOP
        if (stop_cmd) begin
          next_r.st = SPM_STOP;
        end else if (halt_cmd) begin
          next_r.st = SPM_HALT;
        end
      end
      SPM_HALT: begin
        // [RQ5] interrupt releases halt
        if (int_s || nmi_edge || !xrst_n_s) begin
          next_r.st   = SPM_RUN;
          next_r.wake = 1'b1;
        end
      end
      SPM_STOP: begin
        // [RQ2] only nmi or reset wake
        // [RQ9] nmi edge from clock chip
        if (nmi_edge || !xrst_n_s) begin
          next_r.st  = SPM_WARM;
          next_r.cnt = WAKE_LOAD;
        end
      end
      SPM_WARM: begin
        // [RQ3] oscillator settle wait
        // [RQ10] count before clock enable
        if (r.cnt == '0) begin
          next_r.st   = SPM_RUN;
          next_r.wake = 1'b1;
        end else begin
          next_r.cnt = r.cnt - CNT_W'(1);
        end
      end
      default: begin
        next_r.st = SPM_RUN;
      end
    endcase
    // [RQ1] oscillator off only in stop
    next_r.osc_en     = (next_r.st != SPM_STOP);
    // [RQ4] halt keeps peripherals running
    next_r.cpu_run    = (next_r.st == SPM_RUN);
    next_r.periph_run = (next_r.st == SPM_RUN) || (next_r.st == SPM_HALT);
    // [RQ6] supply rise clears flag
    if (rise_edge) begin
      next_r.flag = FLAG_COLD;
    end
    // [RQ7] read returns old value, then sets
    // read after clear so the set wins
    if (flag_rd && r.cpu_run) begin
      next_r.rvalid = 1'b1;
      next_r.rdata  = r.flag;
      next_r.flag   = FLAG_WARM;
    end
  end

  // [RQ8] flag held in every state
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      r <= RST_VAL;
    end else begin
      r <= next_r;
    end
  end

  // ---------------------------------------------------------------
  // outputs, all registered
  // ---------------------------------------------------------------
  assign osc_en       = r.osc_en;
  assign cpu_run      = r.cpu_run;
  assign periph_run   = r.periph_run;
  assign stop_active  = r.st[2];
  assign halt_active  = r.st[1];
  assign wake_pulse   = r.wake;
  assign flag_rvalid  = r.rvalid;
  assign flag_rdata   = r.rdata;
  assign standby_flag = r.flag;

endmodule

// *** design/spm_pkg.sv ***
// Summary of operation
// [RQ1] Two sleep states; the stop command enters STOP, halting oscillator and peripherals.
// [RQ2] STOP is left only on reset or non-maskable interrupt; all else ignored.
// [RQ3] About 50 ms oscillator restart wait after STOP release before execution.
// [RQ4] HALT stops execution; oscillator and peripherals keep running, state kept.
// [RQ5] A maskable interrupt request releases HALT and execution resumes.
// [RQ6] The standby flag is cleared on every supply rise (power-up); a flag read in the same cycle sets it instead.
// [RQ7] Reading the standby flag sets it; later reads return set.
// [RQ8] Flag value is held through run, HALT and STOP.
// [RQ9] Jumpered real-time clock drives the non-maskable request that ends STOP.
// [RQ10] Wake sequencer counts a configurable cycle count before re-enabling clocks.
package spm_pkg;

  // ---------------------------------------------------------------
  // timing
  // ---------------------------------------------------------------
  localparam longint unsigned CLK_HZ          = 64'd20_000_000;
  localparam longint unsigned OSC_RESTART_MS  = 64'd50;
  localparam longint unsigned MS_PER_S        = 64'd1000;
  // least time, so round up
  localparam longint unsigned OSC_RESTART_CYC =
    (OSC_RESTART_MS * CLK_HZ + MS_PER_S - 64'd1) / MS_PER_S;
  localparam int unsigned     WAKE_CNT_W      = 24;

  // ---------------------------------------------------------------
  // reset values and states
  // ---------------------------------------------------------------
  localparam logic FLAG_COLD = 1'b0;
  localparam logic FLAG_WARM = 1'b1;

  typedef enum logic [3:0] {
    SPM_RUN  = 4'b0001,
    SPM_HALT = 4'b0010,
    SPM_STOP = 4'b0100,
    SPM_WARM = 4'b1000
  } spm_state_t;

endpackage

// *** design/spm_sync.sv ***
`timescale 1ns/1ns
module spm_sync #(
  parameter int unsigned W = 4
) (
  input  wire logic         core_clk,
  input  wire logic         nrst,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  import spm_pkg::*;

  // ---------------------------------------------------------------
  // two-stage synchroniser
  // ---------------------------------------------------------------
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } spm_sync_t;

  spm_sync_t r;
  spm_sync_t next_r;

  always_comb begin
    next_r    = r;
    next_r.s1 = d;
    next_r.s2 = r.s1;
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      r <= '0;
    end else begin
      r <= next_r;
    end
  end

  assign q = r.s2;

endmodule

// *** tb/spm_ctrl_asserts.sv ***
`timescale 1ns/1ns
module spm_ctrl_asserts (
  input wire logic core_clk, nrst, stop_cmd, halt_cmd, flag_rd, osc_en, cpu_run, periph_run,
  input wire logic stop_active, halt_active, wake_pulse, flag_rvalid, flag_rdata, standby_flag
);
  // --
  // sleep and flag
  // --
  default clocking @(posedge core_clk); endclocking
  default disable iff (!nrst);
  stop_entry_a: assert property (stop_cmd && cpu_run |=> stop_active && !osc_en) else $error("no stop");
  stop_off_a: assert property (stop_active |-> !(osc_en || cpu_run || periph_run)) else $error("stop clk");
  halt_entry_a: assert property (halt_cmd && !stop_cmd && cpu_run |=> halt_active) else $error("no halt");
  halt_run_a: assert property (halt_active |-> osc_en && periph_run && !cpu_run) else $error("halt clk");
  warm_len_a: assert property ($fell(stop_active) |-> !cpu_run [*8] ##1 wake_pulse) else $error("warm");
  flag_set_a: assert property (flag_rd && cpu_run |=> flag_rvalid && standby_flag) else $error("flag");
  flag_old_a: assert property (flag_rvalid |-> flag_rdata == $past(standby_flag)) else $error("rdata");
  flag_keep_a: assert property ($rose(standby_flag) |-> $past(flag_rd) && $past(cpu_run)) else $error("set");
endmodule
bind spm_ctrl spm_ctrl_asserts u_chk(.core_clk, .nrst, .stop_cmd, .halt_cmd, .flag_rd, .osc_en, .cpu_run,
  .periph_run, .stop_active, .halt_active, .wake_pulse, .flag_rvalid, .flag_rdata, .standby_flag);

// *** tb/spm_ctrl_tb.sv ***
`timescale 1ns/1ns
module spm_ctrl_tb;
  // --
  // bench
  // --
  logic core_clk = 1'h0, nrst = 1'h0, stop_cmd = 1'h0, halt_cmd = 1'h0, flag_rd = 1'h0;
  logic int_req = 1'h0, ext_rst_n = 1'h1, supply_rise = 1'h0, fire = 1'h0, nmi_req;
  logic osc_en, cpu_run, periph_run, stop_active, halt_active, wake_pulse, flag_rvalid;
  logic flag_rdata, standby_flag;
  int   mismatches = 0, n_checks = 0;
  wire  [4:0] st = {osc_en, cpu_run, periph_run, stop_active, halt_active};
  // short warm-up keeps the run brief
  spm_ctrl #(.WAKE_CYCLES(8)) dut(.core_clk, .nrst, .stop_cmd, .halt_cmd, .flag_rd, .nmi_req,
    .int_req, .ext_rst_n, .supply_rise, .osc_en, .cpu_run, .periph_run, .stop_active,
    .halt_active, .wake_pulse, .flag_rvalid, .flag_rdata, .standby_flag);
  spm_rtc rtc(.core_clk, .fire, .nmi_req);
  initial forever #25 core_clk = ~core_clk;
  task automatic chk(logic [4:0] got, logic [4:0] exp);
    n_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic step(int n);
    repeat (n) @(posedge core_clk);
    #5;
  endtask
  task automatic close_out;
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task automatic t_flag;
    flag_rd = 1'h1;
    step(1);
    chk({flag_rvalid, flag_rdata, standby_flag}, 5'h05);
    step(1);
    flag_rd = 1'h0;
    chk({flag_rvalid, flag_rdata, standby_flag}, 5'h07);
    $display("flag done");
  endtask
  task automatic t_halt;
    halt_cmd = 1'h1;
    step(1);
    halt_cmd = 1'h0;
    flag_rd = 1'h1;
    chk(st, 5'h15);
    step(1);
    flag_rd = 1'h0;
    int_req = 1'h1;
    chk({flag_rvalid, standby_flag}, 5'h01);
    step(2);
    chk(st, 5'h15);
    step(1);
    chk({cpu_run, halt_active, wake_pulse}, 5'h05);
    $display("halt done");
  endtask
  // int_req left high from halt so stop sees a live request
  task automatic t_stop;
    stop_cmd = 1'h1;
    step(1);
    stop_cmd = 1'h0;
    chk(st, 5'h02);
    step(5);
    chk(st, 5'h02);
    int_req = 1'h0;
    fire = 1'h1;
    step(1);
    fire = 1'h0;
    step(3);
    chk(st, 5'h10);
    step(7);
    chk(st, 5'h10);
    step(1);
    chk(st, 5'h1c);
    chk({cpu_run, wake_pulse, standby_flag}, 5'h07);
    $display("stop done");
  endtask
  task automatic t_supply;
    supply_rise = 1'h1;
    step(2);
    chk(standby_flag, 5'h01);
    step(1);
    supply_rise = 1'h0;
    flag_rd = 1'h1;
    chk(standby_flag, 5'h00);
    step(1);
    flag_rd = 1'h0;
    chk({flag_rvalid, flag_rdata, standby_flag}, 5'h05);
    $display("supply done");
  endtask
  task automatic t_xrst;
    stop_cmd = 1'h1;
    step(1);
    stop_cmd = 1'h0;
    ext_rst_n = 1'h0;
    chk(st, 5'h02);
    step(3);
    ext_rst_n = 1'h1;
    chk(st, 5'h10);
    step(8);
    chk(st, 5'h1c);
    chk({cpu_run, wake_pulse, standby_flag}, 5'h07);
    $display("xrst done");
  endtask
  initial begin
    step(10);
    nrst = 1'h1;
    step(3);
    t_flag();
    t_halt();
    t_stop();
    t_supply();
    t_xrst();
    close_out();
  end
endmodule

// *** tb/spm_rtc.sv ***
`timescale 1ns/1ns
module spm_rtc (
  input  wire logic core_clk,
  input  wire logic fire,
  output logic      nmi_req
);
  // --
  // alarm line
  // --
  initial nmi_req = 1'h0;
  always @(posedge core_clk) nmi_req <= #1 fire;
endmodule
